// File: rtl/csd_pkg.sv
// package for the console scan display: timing, widths, switch bundles
// assumes a single 125 MHz system clock
package csd_pkg;
    localparam int unsigned CLK_MHZ        = 125;
    localparam int unsigned STATE_TIME_NS  = 1000; // one counter state, about 1 us
    localparam int unsigned STATE_CYCLES   = (STATE_TIME_NS * CLK_MHZ) / 1000;
    localparam int unsigned HALF_CYCLES    = STATE_CYCLES / 2;
    localparam int unsigned CNT_W          = 8;
    localparam int unsigned NIB_W          = 4;
    localparam int unsigned DISP_W         = 16;
    localparam int unsigned DIV_W          = 16;
    localparam logic [CNT_W-1:0] CNT_RESET = 8'h00;
    localparam logic [NIB_W-1:0] NIB_MAX   = 4'hF;
    localparam logic [DISP_W-1:0] DISP_RESET = 16'h0000;

    // raw contact pairs of one switch: rest and active terminals, high when closed
    typedef struct packed {
        logic rest;
        logic active;
    } csd_contact_t;

    // the six control switches
    typedef struct packed {
        csd_contact_t set_pointer_key;
        csd_contact_t inspect_key;
        csd_contact_t continue_key;
        csd_contact_t store_key;
        csd_contact_t start_key;
        csd_contact_t halt_toggle;
    } csd_keys_t;

    // latched switch outputs, active low
    typedef struct packed {
        logic set_pointer_key_n;
        logic inspect_key_n;
        logic continue_key_n;
        logic store_key_n;
        logic start_key_n;
        logic halt_n;
    } csd_key_out_t;
endpackage

// File: rtl/csd_console_scan_display.sv
// console scan display: scan counter, display shift register, switch latches
// assumes datapath selector outside returns the selected bit inverted, synchronous to sys_clk
// assumes switch contacts, power good and panel lock arrive as levels synchronous to sys_clk
// assumes STATE_CYCLES system clocks make one console clock period, about a microsecond
`timescale 1ns/10ps
`default_nettype none
module csd_console_scan_display #(
    parameter int unsigned STATE_CYCLES = csd_pkg::STATE_CYCLES
) (
    input  wire logic                        sys_clk,
    input  wire logic                        resetn,
    input  wire logic                        clk_en,
    input  wire logic                        power_good,
    input  wire logic                        panel_lock,
    input  wire logic                        serial_in,
    output logic      [csd_pkg::NIB_W-1:0]   scan_select,
    output logic                             shift_enable,
    output logic      [csd_pkg::DISP_W-1:0]  indicators,
    input  wire logic [csd_pkg::DISP_W-1:0]  entry_switch_up,
    output logic      [csd_pkg::DISP_W-1:0]  entry_data,
    input  wire csd_pkg::csd_keys_t          keys,
    output csd_pkg::csd_key_out_t            key_out
);
    import csd_pkg::*;

    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(STATE_CYCLES - 1);
    localparam logic [DIV_W-1:0] DIV_HALF = DIV_W'(STATE_CYCLES / 2);
    // bit positions of the six latched switch outputs, halt in the lsb
    localparam int unsigned KEY_N        = $bits(csd_key_out_t);
    localparam int unsigned KEY_POINTER  = 5;
    localparam int unsigned KEY_INSPECT  = 4;
    localparam int unsigned KEY_CONTINUE = 3;
    localparam int unsigned KEY_STORE    = 2;
    localparam int unsigned KEY_START    = 1;
    localparam int unsigned KEY_HALT     = 0;

    logic [DIV_W-1:0]  div_reg;
    logic [CNT_W-1:0]  count_reg;
    logic [DISP_W-1:0] disp_reg;
    logic              lock_in;
    logic              tick_rise;
    logic              tick_fall;
    csd_key_out_t      key_reg;
    // counter sections and the carry between them
    logic [NIB_W-1:0]  low_reg;
    logic [NIB_W-1:0]  high_reg;
    logic [NIB_W:0]    low_step;
    logic [NIB_W:0]    high_step;
    logic              low_carry;
    // switch latch inputs, low active, and the latch flip-flops
    logic [KEY_N-1:0]  set_low;
    logic [KEY_N-1:0]  reset_low;
    logic              set_pointer_n_reg;
    logic              inspect_n_reg;
    logic              continue_n_reg;
    logic              store_n_reg;
    logic              start_n_reg;
    logic              halt_n_reg;

    // set/reset latch step: rest closed sets (high), active closed resets (low)
    function automatic logic latch_step(input logic q, input logic s_low, input logic r_low);
        logic n;
        n = q;
        if (!s_low && r_low) begin
            n = 1'b1;
        end else if (s_low && !r_low) begin
            n = 1'b0;
        end
        return n;
    endfunction

    // console clock: divider runs only with power good, restarts from zero on power up
    // a dropped power good stops it at once, so neither counter nor display can move
    // until power is back; one divider period stands for one console clock period
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            div_reg <= '0;
        end else if (clk_en) begin
            if (!power_good) begin
                div_reg <= '0;
            end else if (div_reg == DIV_LAST) begin
                div_reg <= '0;
            end else begin
                div_reg <= div_reg + 1'b1;
            end
        end
    end

    // rising and falling edges of the console clock
    assign tick_rise = power_good && (div_reg == DIV_LAST);
    assign tick_fall = power_good && (div_reg == DIV_HALF);

    // nibble increment with carry out: {carry, next value}
    // used for both counter sections, so both wrap the same way
    function automatic logic [NIB_W:0] nib_step(input logic [NIB_W-1:0] v, input logic up);
        logic [NIB_W:0] r;
        r = {1'b0, v};
        if (up) begin
            r = {1'b0, v} + {{NIB_W{1'b0}}, 1'b1};
        end
        return r;
    endfunction

    // low section steps on every console clock rise, high section on its carry
    always_comb begin
        low_step  = nib_step(low_reg, tick_rise);
        low_carry = tick_rise && low_step[NIB_W];
        high_step = nib_step(high_reg, low_carry);
    end

    // low section of the scan counter; no load or clear path reaches it
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            low_reg <= CNT_RESET[NIB_W-1:0];
        end else if (clk_en && tick_rise) begin
            low_reg <= low_step[NIB_W-1:0];
        end
    end

    // high section of the scan counter; wraps from all ones to zero with the low one
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            high_reg <= CNT_RESET[CNT_W-1:NIB_W];
        end else if (clk_en && low_carry) begin
            high_reg <= high_step[NIB_W-1:0];
        end
    end

    // the whole counter as one word for the decoders below
    assign count_reg = {high_reg, low_reg};

    // selector lines: inverted low section, so state 0 picks the top datapath bit first
    always_comb begin
        scan_select = ~count_reg[NIB_W-1:0];
    end

    // shift control: high only while the high section is all zero, the scan phase
    always_comb begin
        shift_enable = (count_reg[CNT_W-1:NIB_W] == '0);
    end

    // display register shifts right on the falling edge during scan
    // the half period after the rise gives the serial bit time to settle
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            disp_reg <= DISP_RESET;
        end else if (clk_en && tick_fall && shift_enable) begin
            disp_reg <= {serial_in, disp_reg[DISP_W-1:1]};
        end
    end

    // indicators straight from the display flip-flops
    assign indicators = disp_reg;

    // entry switches, down gives low
    // one register stage, so a switch change shows on entry_data one clock later
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            entry_data <= '0;
        end else if (clk_en) begin
            entry_data <= entry_switch_up;
        end
    end

    // lockout level: high only with power good and panel lock both high
    // panel lock is meant to go on while a program runs with every latch set
    assign lock_in = power_good && panel_lock;

    // one contact into a latch input: lockout forces it high, a closed contact pulls low
    function automatic logic gate_in(input logic lock, input logic contact);
        logic g;
        g = lock || !contact;
        return g;
    endfunction

    // latch inputs, low active; with lockout both inputs of a latch sit high and it holds
    always_comb begin
        set_low[KEY_POINTER]    = gate_in(lock_in, keys.set_pointer_key.rest);
        reset_low[KEY_POINTER]  = gate_in(lock_in, keys.set_pointer_key.active);
        set_low[KEY_INSPECT]    = gate_in(lock_in, keys.inspect_key.rest);
        reset_low[KEY_INSPECT]  = gate_in(lock_in, keys.inspect_key.active);
        set_low[KEY_CONTINUE]   = gate_in(lock_in, keys.continue_key.rest);
        reset_low[KEY_CONTINUE] = gate_in(lock_in, keys.continue_key.active);
        set_low[KEY_STORE]      = gate_in(lock_in, keys.store_key.rest);
        reset_low[KEY_STORE]    = gate_in(lock_in, keys.store_key.active);
        set_low[KEY_START]      = gate_in(lock_in, keys.start_key.rest);
        reset_low[KEY_START]    = gate_in(lock_in, keys.start_key.active);
        set_low[KEY_HALT]       = gate_in(lock_in, keys.halt_toggle.rest);
        // a power dip frees the panel but must never take the halt position
        reset_low[KEY_HALT]     = gate_in(lock_in || !power_good, keys.halt_toggle.active);
    end

    // set-pointer key latch; bounce opens both contacts and the latch holds
    // output low while the key is operated
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            set_pointer_n_reg <= 1'b1;
        end else if (clk_en) begin
            set_pointer_n_reg <= latch_step(set_pointer_n_reg,
                set_low[KEY_POINTER],
                reset_low[KEY_POINTER]);
        end
    end

    // inspect key latch
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            inspect_n_reg <= 1'b1;
        end else if (clk_en) begin
            inspect_n_reg <= latch_step(inspect_n_reg,
                set_low[KEY_INSPECT],
                reset_low[KEY_INSPECT]);
        end
    end

    // continue key latch
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            continue_n_reg <= 1'b1;
        end else if (clk_en) begin
            continue_n_reg <= latch_step(continue_n_reg,
                set_low[KEY_CONTINUE],
                reset_low[KEY_CONTINUE]);
        end
    end

    // store key latch; its active contact is the lifted one, wired the same way
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            store_n_reg <= 1'b1;
        end else if (clk_en) begin
            store_n_reg <= latch_step(store_n_reg,
                set_low[KEY_STORE],
                reset_low[KEY_STORE]);
        end
    end

    // start key latch
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            start_n_reg <= 1'b1;
        end else if (clk_en) begin
            start_n_reg <= latch_step(start_n_reg,
                set_low[KEY_START],
                reset_low[KEY_START]);
        end
    end

    // halt toggle latch: low in the halt position, held through a power dip
    // so a toggle left down under panel lock cannot stop a running program
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            halt_n_reg <= 1'b1;
        end else if (clk_en) begin
            halt_n_reg <= latch_step(halt_n_reg,
                set_low[KEY_HALT],
                reset_low[KEY_HALT]);
        end
    end

    // latched switch outputs gathered in the order of the output bundle
    // halt lands in the lsb
    always_comb begin
        key_reg.set_pointer_key_n = set_pointer_n_reg;
        key_reg.inspect_key_n     = inspect_n_reg;
        key_reg.continue_key_n    = continue_n_reg;
        key_reg.store_key_n       = store_n_reg;
        key_reg.start_key_n       = start_n_reg;
        key_reg.halt_n            = halt_n_reg;
    end

    // outputs straight from the latch flip-flops
    assign key_out = key_reg;
endmodule
`default_nettype wire

// File: verif/csd_scan_asserts.sv
// checker: port assertions for the console scan display
// assumes a bind onto csd_console_scan_display, one clock domain
`timescale 1ns/10ps
`default_nettype none
module csd_scan_asserts import csd_pkg::*; (
    input wire logic              sys_clk,
    input wire logic              resetn,
    input wire logic              power_good,
    input wire logic              panel_lock,
    input wire logic [NIB_W-1:0]  scan_select,
    input wire logic              shift_enable,
    input wire logic [DISP_W-1:0] indicators,
    input wire csd_keys_t         keys,
    input wire csd_key_out_t      key_out
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    // counter, display register and switch latch relations
    property p_sel; $changed(scan_select) |-> scan_select == $past(scan_select) - 4'h1; endproperty
    a_sel: assert property (p_sel) else $error("select step wrong");
    property p_fall; $fell(shift_enable) |-> scan_select == 4'hF; endproperty
    a_fall: assert property (p_fall) else $error("scan end wrong");
    property p_shift; $changed(indicators) |-> indicators[14:0] == $past(indicators[15:1]); endproperty
    a_shift: assert property (p_shift) else $error("shift not right");
    property p_hold; !$past(shift_enable) |-> $stable(indicators); endproperty
    a_hold: assert property (p_hold) else $error("display moved in hold");
    property p_pwr; !power_good [*2] |-> $stable(scan_select) && $stable(indicators); endproperty
    a_pwr: assert property (p_pwr) else $error("clock ran without power");
    property p_lock; $past(power_good && panel_lock) |-> $stable(key_out); endproperty
    a_lock: assert property (p_lock) else $error("keys not locked");
    property p_halt; $past(!power_good) |-> !$fell(key_out.halt_n); endproperty
    a_halt: assert property (p_halt) else $error("halt moved without power");
    property p_key; power_good && !panel_lock && keys == 12'h555 |=> key_out == 6'h00; endproperty
    a_key: assert property (p_key) else $error("key not asserted low");
endmodule
bind csd_console_scan_display csd_scan_asserts u_chk (.*);
`default_nettype wire

// File: verif/csd_datapath_model.sv
// partner: processor datapath selector feeding the serial line
// assumes the bench sets the datapath value
`timescale 1ns/10ps
`default_nettype none
module csd_datapath_model import csd_pkg::*; (
    input  wire logic [NIB_W-1:0]  scan_select,
    input  wire logic [DISP_W-1:0] datapath,
    output logic                   serial_in
);
    // selected bit goes out inverted
    assign serial_in = ~datapath[scan_select];
endmodule
`default_nettype wire

// File: verif/testbench.sv
// testbench: scan display with datapath model and bound checker
// assumes four system clocks per counter state
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import csd_pkg::*;
    logic sys_clk = 1'b0, resetn = 1'b0, clk_en = 1'b1, power_good = 1'b1, panel_lock = 1'b0;
    logic [15:0] dp = 16'hA5C3, sw = 16'h0000, ind, ent, hold_val, exp;
    logic [3:0]   sel;
    logic         shen, ser;
    csd_keys_t    keys = 12'hAAA;
    csd_key_out_t kout;
    int           fail_count = 0, n_tests = 0, n;
    always #4 sys_clk = ~sys_clk;
    csd_console_scan_display #(.STATE_CYCLES(4)) uut (.sys_clk(sys_clk), .resetn(resetn),
        .clk_en(clk_en), .power_good(power_good), .panel_lock(panel_lock), .serial_in(ser),
        .scan_select(sel), .shift_enable(shen), .indicators(ind), .entry_switch_up(sw),
        .entry_data(ent), .keys(keys), .key_out(kout));
    csd_datapath_model far (.scan_select(sel), .datapath(dp), .serial_in(ser));
    task automatic chk(input logic [15:0] got, input logic [15:0] want);
        n_tests++;
        if (got !== want) begin
            fail_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask
    task automatic complete_run;
        if (fail_count == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // wait for the next end of scan, counting cycles
    task automatic wait_fall;
        n = 0;
        while (shen !== 1'b1 && n < 2000) begin @(negedge sys_clk); n++; end
        while (shen !== 1'b0 && n < 2000) begin @(negedge sys_clk); n++; end
        if (n >= 2000) begin fail_count++; complete_run(); end
    endtask
    // main sequence: scan, hold, wrap, entry, power loss, keys
    initial begin
        repeat (3) @(posedge sys_clk);
        resetn <= 1'b1;
        wait_fall();
        exp = {<<{~dp}};
        chk(ind, exp);
        @(posedge sys_clk);
        dp <= 16'h0F01;
        repeat (100) @(negedge sys_clk);
        chk(ind, exp);
        wait_fall();
        chk(n[15:0], 16'h039C);
        exp = {<<{~dp}};
        chk(ind, exp);
        @(posedge sys_clk);
        sw <= 16'h9A3C;
        power_good <= 1'b0;
        keys <= 12'h555;
        repeat (3) @(negedge sys_clk);
        chk(ent, sw);
        chk({10'h000, kout}, 16'h0001);
        hold_val = {12'h000, sel};
        repeat (40) @(negedge sys_clk);
        chk({12'h000, sel}, hold_val);
        @(posedge sys_clk);
        power_good <= 1'b1;
        repeat (3) @(negedge sys_clk);
        chk({10'h000, kout}, 16'h0000);
        @(posedge sys_clk);
        keys <= 12'h000;
        repeat (3) @(negedge sys_clk);
        chk({10'h000, kout}, 16'h0000);
        @(posedge sys_clk);
        keys <= 12'hAAA;
        repeat (3) @(negedge sys_clk);
        chk({10'h000, kout}, 16'h003F);
        @(posedge sys_clk);
        clk_en <= 1'b0;
        repeat (2) @(negedge sys_clk);
        hold_val = {12'h000, sel};
        repeat (20) @(negedge sys_clk);
        chk({12'h000, sel}, hold_val);
        @(posedge sys_clk);
        clk_en <= 1'b1;
        @(posedge sys_clk);
        panel_lock <= 1'b1;
        keys <= 12'h555;
        repeat (3) @(negedge sys_clk);
        chk({10'h000, kout}, 16'h003F);
        @(posedge sys_clk);
        keys <= 12'hAA9;
        power_good <= 1'b0;
        repeat (3) @(negedge sys_clk);
        chk({10'h000, kout}, 16'h003F);
        @(posedge sys_clk);
        power_good <= 1'b1;
        repeat (3) @(negedge sys_clk);
        chk({10'h000, kout}, 16'h003F);
        complete_run();
    end
endmodule
`default_nettype wire
